// >>> verilog/mbpm_pin_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module mbpm_pin_ctrl
	import mbpm_pkg::*;
#(
	parameter int PORT_W = MBPM_PORT_W
) (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic core_rst_in,
	input wire logic [1:0] mode_strap_in,
	input wire logic shutdown_in,
	input wire logic quiet_in,
	input wire mbpm_bus_req_t bus_req_in,
	input wire logic decode_a_hit_in,
	input wire logic decode_b_hit_in,
	input wire logic decode_c_hit_in,
	input wire logic core_clk_sel_in,
	input wire logic core_clk_in,
	input wire logic emu_int_a_in,
	input wire logic emu_int_b_in,
	input wire logic [PORT_W-1:0] gpio_sfr_in,
	input wire logic [PORT_W-1:0] hi_sfr_in,
	input wire logic [PORT_W-1:0] gpio_pu_dis_in,
	input wire logic [PORT_W-1:0] hi_pu_dis_in,
	input wire logic [PORT_W-1:0] gpio_chg_en_in,
	input wire logic [PORT_W-1:0] low_addr_data_port_in,
	input wire logic [PORT_W-1:0] general_io_port_in,
	input wire logic latch_strobe_in,
	input wire logic rd_strobe_n_in,
	input wire logic wr_strobe_n_in,
	output logic [PORT_W-1:0] low_addr_data_port_out,
	output logic [PORT_W-1:0] low_addr_data_port_oe_out,
	output logic [PORT_W-1:0] low_addr_data_port_pu_out,
	output logic [PORT_W-1:0] high_addr_port_out,
	output logic [PORT_W-1:0] high_addr_port_oe_out,
	output logic [PORT_W-1:0] high_addr_port_pu_out,
	output logic [PORT_W-1:0] general_io_port_out,
	output logic [PORT_W-1:0] general_io_port_oe_out,
	output logic [PORT_W-1:0] general_io_port_pu_out,
	output logic [PORT_W-1:0] gpio_change_out,
	output logic latch_strobe_out,
	output logic latch_strobe_oe_out,
	output logic rd_strobe_n_out,
	output logic rd_strobe_n_oe_out,
	output logic wr_strobe_n_out,
	output logic wr_strobe_n_oe_out,
	output logic prog_strobe_n_out,
	output logic prog_strobe_n_oe_out,
	output logic prog_strobe_n_pu_out,
	output logic select_decode_a_out,
	output logic select_decode_b_out,
	output logic select_c_or_core_clock_pin_out,
	output logic emul_mode_out,
	output logic ext_bus_enable_out,
	output logic emu_rd_out,
	output logic emu_wr_out,
	output logic emu_latch_out
);

	mbpm_pin_mode_t mode;
	logic emul_sel;
	logic [PORT_W-1:0] chg;
	logic ext_ok;
	logic [PORT_W-1:0] low_last_r;
	logic [PORT_W-1:0] low_drv_nxt;
	logic [PORT_W-1:0] hi_drv_nxt;

	////////////////////////////////////////////////////////////////////////
	// Mode selection and change detection

	mbpm_mode_sel u_mode (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.core_rst_in(core_rst_in),
		.mode_strap_in(mode_strap_in),
		.shutdown_in(shutdown_in),
		.quiet_in(quiet_in),
		.emul_sel_out(emul_sel),
		.mode_out(mode)
	);

	mbpm_change_det #(.WIDTH(PORT_W)) u_chg (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.level_in(general_io_port_in),
		.enable_in(gpio_chg_en_in),
		.change_out(chg)
	);

	assign ext_ok = (mode == MBPM_PIN_NORMAL);

	always_comb begin
		if (bus_req_in.addr_phase) begin
			low_drv_nxt = bus_req_in.addr[7:0];
		end else begin
			low_drv_nxt = bus_req_in.wdata;
		end
		if (bus_req_in.ri_access) begin
			hi_drv_nxt = hi_sfr_in;
		end else begin
			hi_drv_nxt = bus_req_in.addr[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Low port: remembers last driven level for shutdown

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			low_last_r <= '1;
		end else if (ext_ok && (bus_req_in.addr_phase ||
			bus_req_in.data_drive)) begin
			low_last_r <= low_drv_nxt;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			low_addr_data_port_out <= '1;
			low_addr_data_port_oe_out <= '0;
			low_addr_data_port_pu_out <= '1;
		end else begin
			unique case (mode)
			MBPM_PIN_RESET: begin
				low_addr_data_port_out <= '1;
				low_addr_data_port_oe_out <= '0;
				low_addr_data_port_pu_out <= '1;
			end
			MBPM_PIN_SHUTDOWN: begin
				// Zeros held strongly, ones held by pull-up only
				low_addr_data_port_out <= low_last_r;
				low_addr_data_port_oe_out <= ~low_last_r;
				low_addr_data_port_pu_out <= low_last_r;
			end
			MBPM_PIN_EMUL, MBPM_PIN_QUIET: begin
				low_addr_data_port_out <= '0;
				low_addr_data_port_oe_out <= '0;
				low_addr_data_port_pu_out <= '0;
			end
			MBPM_PIN_NORMAL: begin
				low_addr_data_port_out <= low_drv_nxt;
				low_addr_data_port_oe_out <= {PORT_W{bus_req_in.addr_phase ||
					bus_req_in.data_drive}};
				low_addr_data_port_pu_out <= '0;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// High port

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			high_addr_port_out <= '1;
			high_addr_port_oe_out <= '0;
			high_addr_port_pu_out <= '1;
		end else begin
			unique case (mode)
			MBPM_PIN_RESET, MBPM_PIN_SHUTDOWN: begin
				high_addr_port_out <= '1;
				high_addr_port_oe_out <= '0;
				high_addr_port_pu_out <= ~hi_pu_dis_in;
			end
			MBPM_PIN_EMUL, MBPM_PIN_QUIET: begin
				high_addr_port_out <= '0;
				high_addr_port_oe_out <= '0;
				high_addr_port_pu_out <= '0;
			end
			MBPM_PIN_NORMAL: begin
				if (bus_req_in.fetch || bus_req_in.dptr_access ||
					bus_req_in.ri_access) begin
					high_addr_port_out <= hi_drv_nxt;
					high_addr_port_oe_out <= '1;
				end else begin
					high_addr_port_out <= hi_sfr_in;
					high_addr_port_oe_out <= ~hi_sfr_in;
				end
				high_addr_port_pu_out <= ~hi_pu_dis_in;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// General port

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			general_io_port_out <= MBPM_GPIO_RST;
			general_io_port_oe_out <= '0;
			general_io_port_pu_out <= '1;
		end else begin
			unique case (mode)
			MBPM_PIN_RESET: begin
				general_io_port_out <= MBPM_GPIO_RST;
				general_io_port_oe_out <= '0;
				general_io_port_pu_out <= '1;
			end
			MBPM_PIN_EMUL: begin
				general_io_port_out <= '0;
				general_io_port_oe_out <= '0;
				general_io_port_pu_out <= '0;
			end
			// Shutdown keeps the programmed values as in normal running
			MBPM_PIN_SHUTDOWN, MBPM_PIN_QUIET, MBPM_PIN_NORMAL: begin
				general_io_port_out <= gpio_sfr_in;
				general_io_port_oe_out <= ~gpio_sfr_in;
				general_io_port_pu_out <= gpio_sfr_in &
					~gpio_pu_dis_in;
			end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			gpio_change_out <= '0;
		end else begin
			gpio_change_out <= chg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Strobes and select pins

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			latch_strobe_out <= 1'b0;
			latch_strobe_oe_out <= 1'b0;
			rd_strobe_n_out <= MBPM_STROBE_IDLE;
			rd_strobe_n_oe_out <= 1'b0;
			wr_strobe_n_out <= MBPM_STROBE_IDLE;
			wr_strobe_n_oe_out <= 1'b0;
			prog_strobe_n_out <= MBPM_STROBE_IDLE;
			prog_strobe_n_oe_out <= 1'b0;
			prog_strobe_n_pu_out <= 1'b1;
		end else begin
			latch_strobe_out <= ext_ok && bus_req_in.addr_phase;
			latch_strobe_oe_out <= (mode != MBPM_PIN_EMUL) &&
				(mode != MBPM_PIN_QUIET);
			rd_strobe_n_out <= !(ext_ok && bus_req_in.rd_strobe);
			wr_strobe_n_out <= !(ext_ok && bus_req_in.wr_strobe);
			rd_strobe_n_oe_out <= ext_ok;
			wr_strobe_n_oe_out <= ext_ok;
			prog_strobe_n_out <= !(ext_ok && bus_req_in.prog_strobe);
			prog_strobe_n_oe_out <= (mode == MBPM_PIN_NORMAL) ||
				(mode == MBPM_PIN_QUIET);
			prog_strobe_n_pu_out <= (mode != MBPM_PIN_EMUL);
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			select_decode_a_out <= 1'b1;
			select_decode_b_out <= 1'b1;
			select_c_or_core_clock_pin_out <= 1'b1;
		end else begin
			if (emul_sel) begin
				select_decode_a_out <= emu_int_a_in;
				select_decode_b_out <= emu_int_b_in;
			end else begin
				select_decode_a_out <= !decode_a_hit_in;
				select_decode_b_out <= !decode_b_hit_in;
			end
			if (core_clk_sel_in || emul_sel) begin
				select_c_or_core_clock_pin_out <= core_clk_in;
			end else begin
				select_c_or_core_clock_pin_out <= !decode_c_hit_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Emulator access inputs toward the core

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			emul_mode_out <= 1'b0;
			ext_bus_enable_out <= 1'b0;
			emu_rd_out <= 1'b0;
			emu_wr_out <= 1'b0;
			emu_latch_out <= 1'b0;
		end else begin
			emul_mode_out <= emul_sel;
			ext_bus_enable_out <= ext_ok;
			emu_rd_out <= (mode == MBPM_PIN_EMUL) && !rd_strobe_n_in;
			emu_wr_out <= (mode == MBPM_PIN_EMUL) && !wr_strobe_n_in;
			emu_latch_out <= (mode == MBPM_PIN_EMUL) && latch_strobe_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_quiet_bus_off: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		(mode == MBPM_PIN_QUIET) |=> (!rd_strobe_n_oe_out &&
		!wr_strobe_n_oe_out && high_addr_port_oe_out == '0))
		else $error("bus driven in quiet mode");

	a_emul_float: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		(mode == MBPM_PIN_EMUL) |=> (low_addr_data_port_oe_out == '0 &&
		general_io_port_oe_out == '0 && !prog_strobe_n_oe_out))
		else $error("pins driven in emulation");

	a_reset_weak_hi: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		core_rst_in |=> (general_io_port_pu_out == '1 &&
		low_addr_data_port_pu_out == '1))
		else $error("ports not weak high in reset");

	a_latch_addr: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		(ext_ok && bus_req_in.addr_phase) |=> (latch_strobe_out &&
		low_addr_data_port_out == $past(bus_req_in.addr[7:0])))
		else $error("latch strobe without address");

	a_sel_a_decode: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		(!emul_sel && decode_a_hit_in) |=> !select_decode_a_out)
		else $error("decode a not low");

	a_sel_b_int: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		emul_sel |=> (select_decode_b_out == $past(emu_int_b_in)))
		else $error("interrupt b not passed");

	a_ri_high_sfr: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		(ext_ok && bus_req_in.ri_access) |=>
		(high_addr_port_out == $past(hi_sfr_in)))
		else $error("high port not register value");

	a_wr_strobe: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		(ext_ok && bus_req_in.wr_strobe) |=> (!wr_strobe_n_out &&
		wr_strobe_n_oe_out))
		else $error("write strobe missing");

	a_pu_disable: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		(mode == MBPM_PIN_NORMAL && gpio_pu_dis_in[0]) |=>
		!general_io_port_pu_out[0])
		else $error("pull-up not disabled");

endmodule : mbpm_pin_ctrl
`default_nettype wire

// >>> verilog/mbpm_pkg.sv
package mbpm_pkg;

	localparam int MBPM_PORT_W = 8;

	// Three-level mode strap encoding
	localparam logic [1:0] MBPM_STRAP_LOW = 2'h0;
	localparam logic [1:0] MBPM_STRAP_HIGH = 2'h1;
	localparam logic [1:0] MBPM_STRAP_OPEN = 2'h2;

	// Reset values
	localparam logic [7:0] MBPM_GPIO_RST = 8'hff;
	localparam logic [7:0] MBPM_HI_SFR_RST = 8'hff;
	localparam logic MBPM_STROBE_IDLE = 1'h1;

	typedef enum logic [2:0] {
		MBPM_PIN_RESET,
		MBPM_PIN_SHUTDOWN,
		MBPM_PIN_EMUL,
		MBPM_PIN_QUIET,
		MBPM_PIN_NORMAL
	} mbpm_pin_mode_t;

	// One pin as seen by the pad: level, strong drive, weak pull-up
	typedef struct packed {
		logic level;
		logic strong_oe;
		logic weak_pu;
	} mbpm_pad_t;

	// Bus cycle request from the core
	typedef struct packed {
		logic addr_phase;
		logic data_drive;
		logic fetch;
		logic dptr_access;
		logic ri_access;
		logic rd_strobe;
		logic wr_strobe;
		logic prog_strobe;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mbpm_bus_req_t;

endpackage : mbpm_pkg

// >>> verilog/mbpm_mode_sel.sv
`timescale 1ns/1ns
`default_nettype none
module mbpm_mode_sel
	import mbpm_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic core_rst_in,
	input wire logic [1:0] mode_strap_in,
	input wire logic shutdown_in,
	input wire logic quiet_in,
	output logic emul_sel_out,
	output mbpm_pin_mode_t mode_out
);

	logic emul_r;

	// Strap is sampled on every clock while reset is held, last sample kept
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			emul_r <= 1'b0;
		end else if (core_rst_in) begin
			emul_r <= (mode_strap_in == MBPM_STRAP_LOW);
		end
	end

	assign emul_sel_out = emul_r;

	always_comb begin
		if (core_rst_in) begin
			mode_out = MBPM_PIN_RESET;
		end else if (shutdown_in) begin
			mode_out = MBPM_PIN_SHUTDOWN;
		end else if (emul_r) begin
			mode_out = MBPM_PIN_EMUL;
		end else if (quiet_in) begin
			mode_out = MBPM_PIN_QUIET;
		end else begin
			mode_out = MBPM_PIN_NORMAL;
		end
	end

endmodule : mbpm_mode_sel
`default_nettype wire

// >>> verilog/mbpm_change_det.sv
`timescale 1ns/1ns
`default_nettype none
module mbpm_change_det
	import mbpm_pkg::*;
#(
	parameter int WIDTH = MBPM_PORT_W
) (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic [WIDTH-1:0] level_in,
	input wire logic [WIDTH-1:0] enable_in,
	output logic [WIDTH-1:0] change_out
);

	logic [WIDTH-1:0] last_r;
	logic [WIDTH-1:0] change_r;

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					last_r[gi] <= 1'b1;
					change_r[gi] <= 1'b0;
				end else begin
					last_r[gi] <= level_in[gi];
					change_r[gi] <= enable_in[gi] &&
						(level_in[gi] != last_r[gi]);
				end
			end
		end
	endgenerate

	assign change_out = change_r;

	a_change_pulse: assert property (@(posedge clk_sys_in)
		disable iff (!arst_n_in)
		(enable_in[0] && $changed(level_in[0])) |=> change_out[0])
		else $error("port change not flagged");

endmodule : mbpm_change_det
`default_nettype wire

// >>> verification/mbpm_ext_model.sv
`timescale 1ns/1ns
`default_nettype none
module mbpm_ext_model (
	input wire logic clk_sys_in,
	input wire logic [7:0] low_in,
	input wire logic [7:0] low_oe_in,
	input wire logic [7:0] low_pu_in,
	input wire logic [7:0] gen_in,
	input wire logic [7:0] gen_oe_in,
	input wire logic [7:0] gen_pu_in,
	input wire logic [7:0] ext_en_in,
	input wire logic [7:0] ext_val_in,
	input wire logic [2:0] str_in,
	input wire logic [2:0] str_oe_in,
	input wire logic emu_drv_in,
	input wire logic [2:0] emu_str_in,
	output logic [7:0] low_port_out,
	output logic [7:0] gen_port_out,
	output logic [2:0] str_out,
	output logic [7:0] addr_low_out
);
	logic [7:0] low_last = 8'h00;
	logic [7:0] gen_last = 8'h00;
	logic [2:0] str_last = 3'h0;

	////////////////////////////////////////////////////////////////////
	// Released lines show ext_val_in where ext_en_in is set (general port only), else the pull-up, else the inverse of the last level
	assign low_port_out = (low_oe_in & low_in) |
		(~low_oe_in & (low_pu_in | ~low_last));
	assign gen_port_out = (gen_oe_in & gen_in) |
		(~gen_oe_in & ext_en_in & ext_val_in) |
		(~gen_oe_in & ~ext_en_in & (gen_pu_in | ~gen_last));
	// Emulator owns latch, read and write strobes while emulating
	assign str_out = (str_oe_in & str_in) |
		(~str_oe_in & (emu_drv_in ? emu_str_in : ~str_last));

	always_ff @(posedge clk_sys_in) begin
		low_last <= low_port_out;
		gen_last <= gen_port_out;
		str_last <= str_out;
	end

	////////////////////////////////////////////////////////////////////
	// External address latch follows the strobe
	always_ff @(posedge clk_sys_in) begin
		if (str_oe_in[2] && str_in[2]) begin
			addr_low_out <= low_port_out;
		end
	end
endmodule : mbpm_ext_model
`default_nettype wire

// >>> verification/mbpm_pin_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module mbpm_pin_ctrl_bench
	import mbpm_pkg::*;
;
	logic clk_sys_in, arst_n_in, core_rst_in, shutdown_in, quiet_in;
	logic [1:0] mode_strap_in;
	mbpm_bus_req_t bus_req_in;
	logic decode_a_hit_in, decode_b_hit_in, decode_c_hit_in;
	logic core_clk_sel_in, core_clk_in, emu_int_a_in, emu_int_b_in;
	logic [7:0] gpio_sfr_in, hi_sfr_in, gpio_pu_dis_in, hi_pu_dis_in;
	logic [7:0] gpio_chg_en_in, low_addr_data_port_in, general_io_port_in;
	logic latch_strobe_in, rd_strobe_n_in, wr_strobe_n_in;
	logic [7:0] low_addr_data_port_out, low_addr_data_port_oe_out;
	logic [7:0] low_addr_data_port_pu_out, high_addr_port_out;
	logic [7:0] high_addr_port_oe_out, high_addr_port_pu_out;
	logic [7:0] general_io_port_out, general_io_port_oe_out;
	logic [7:0] general_io_port_pu_out, gpio_change_out;
	logic [7:0] ext_en, ext_val, addr_seen;
	logic latch_strobe_out, latch_strobe_oe_out, rd_strobe_n_out;
	logic rd_strobe_n_oe_out, wr_strobe_n_out, wr_strobe_n_oe_out;
	logic prog_strobe_n_out, prog_strobe_n_oe_out, prog_strobe_n_pu_out;
	logic select_decode_a_out, select_decode_b_out;
	logic select_c_or_core_clock_pin_out, emul_mode_out;
	logic ext_bus_enable_out, emu_rd_out, emu_wr_out, emu_latch_out;
	logic emu_drv;
	logic [2:0] emu_str;
	int n_fail, n_compared;

	mbpm_pin_ctrl dut_u (.*);
	mbpm_ext_model model_u (.clk_sys_in(clk_sys_in),
		.low_in(low_addr_data_port_out),
		.low_oe_in(low_addr_data_port_oe_out),
		.low_pu_in(low_addr_data_port_pu_out),
		.gen_in(general_io_port_out), .gen_oe_in(general_io_port_oe_out),
		.gen_pu_in(general_io_port_pu_out), .ext_en_in(ext_en),
		.ext_val_in(ext_val),
		.str_in({latch_strobe_out, rd_strobe_n_out, wr_strobe_n_out}),
		.str_oe_in({latch_strobe_oe_out, rd_strobe_n_oe_out,
			wr_strobe_n_oe_out}),
		.emu_drv_in(emu_drv), .emu_str_in(emu_str),
		.low_port_out(low_addr_data_port_in),
		.gen_port_out(general_io_port_in),
		.str_out({latch_strobe_in, rd_strobe_n_in, wr_strobe_n_in}),
		.addr_low_out(addr_seen));

	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic look();
		@(posedge clk_sys_in);
		#1;
	endtask : look

	task automatic core_reset(input logic [1:0] strap);
		@(posedge clk_sys_in);
		core_rst_in <= 1'b1;
		mode_strap_in <= strap;
		repeat (3) look();
		chk({low_addr_data_port_oe_out, low_addr_data_port_pu_out}, 16'h00ff);
		chk({high_addr_port_oe_out, high_addr_port_pu_out}, 16'h00ff);
		chk({general_io_port_oe_out, general_io_port_pu_out}, 16'h00ff);
		@(posedge clk_sys_in);
		core_rst_in <= 1'b0;
		mode_strap_in <= ~strap & 2'h1;
		repeat (2) look();
		chk(emul_mode_out, strap == MBPM_STRAP_LOW);
	endtask : core_reset

	////////////////////////////////////////////////////////////////////////
	task automatic t_bus();
		@(posedge clk_sys_in);
		bus_req_in <= '{addr_phase: 1'b1, fetch: 1'b1, prog_strobe: 1'b1,
			addr: 16'h1234, default: '0};
		@(posedge clk_sys_in);
		bus_req_in <= '{data_drive: 1'b1, wr_strobe: 1'b1, wdata: 8'ha5,
			default: '0};
		#1;
		chk({latch_strobe_out, latch_strobe_oe_out,
			ext_bus_enable_out}, 3'h7);
		chk({low_addr_data_port_out, low_addr_data_port_oe_out}, 16'h34ff);
		chk({high_addr_port_out, high_addr_port_oe_out}, 16'h12ff);
		chk({prog_strobe_n_out, prog_strobe_n_oe_out}, 2'h1);
		@(posedge clk_sys_in);
		bus_req_in <= '{addr_phase: 1'b1, dptr_access: 1'b1,
			addr: 16'h5678, default: '0};
		#1;
		chk(addr_seen, 8'h34);
		chk({low_addr_data_port_out, low_addr_data_port_oe_out}, 16'ha5ff);
		chk({wr_strobe_n_out, wr_strobe_n_oe_out, latch_strobe_out}, 3'h2);
		@(posedge clk_sys_in);
		bus_req_in <= '{rd_strobe: 1'b1, default: '0};
		#1;
		chk({high_addr_port_out, low_addr_data_port_out}, 16'h5678);
		@(posedge clk_sys_in);
		bus_req_in <= '{addr_phase: 1'b1, ri_access: 1'b1,
			addr: 16'h9abc, default: '0};
		#1;
		chk({rd_strobe_n_out, rd_strobe_n_oe_out}, 2'h1);
		@(posedge clk_sys_in);
		bus_req_in <= '0;
		#1;
		chk({high_addr_port_out, low_addr_data_port_out}, 16'h3cbc);
	endtask : t_bus

	task automatic t_sel();
		logic [4:0] hits [3] = '{5'b10100, 5'b01011, 5'b00110};
		logic [2:0] pins [3] = '{3'b010, 3'b101, 3'b110};
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys_in);
			{decode_a_hit_in, decode_b_hit_in, decode_c_hit_in,
				core_clk_sel_in, core_clk_in} <= hits[i];
			look();
			chk({select_decode_a_out, select_decode_b_out,
				select_c_or_core_clock_pin_out}, pins[i]);
		end
	endtask : t_sel

	task automatic t_ports();
		@(posedge clk_sys_in);
		gpio_pu_dis_in <= 8'h03;
		hi_pu_dis_in <= 8'h30;
		repeat (2) look();
		chk(general_io_port_pu_out & 8'h0f, 8'h0c);
		chk(high_addr_port_pu_out & 8'h3c, 8'h0c);
		chk(general_io_port_in & 8'h0c, 8'h0c);
	endtask : t_ports

	task automatic t_change();
		int n;
		n = 0;
		@(posedge clk_sys_in);
		ext_val <= 8'hff;
		ext_en <= 8'hff;
		gpio_chg_en_in <= 8'h01;
		repeat (5) @(posedge clk_sys_in);
		ext_val <= 8'hfc;
		repeat (6) begin
			look();
			if (gpio_change_out !== 8'h00) begin
				n++;
				chk(gpio_change_out, 8'h01);
			end
		end
		chk(16'(n), 16'h1);
	endtask : t_change

	task automatic t_quiet();
		@(posedge clk_sys_in);
		quiet_in <= 1'b1;
		bus_req_in <= '{addr_phase: 1'b1, fetch: 1'b1, prog_strobe: 1'b1,
			addr: 16'h4321, default: '0};
		repeat (2) look();
		chk(ext_bus_enable_out, 1'b0);
		chk({low_addr_data_port_oe_out, high_addr_port_oe_out}, 16'h0);
		chk({latch_strobe_oe_out, rd_strobe_n_oe_out, wr_strobe_n_oe_out,
			prog_strobe_n_oe_out}, 4'h1);
		@(posedge clk_sys_in);
		quiet_in <= 1'b0;
		bus_req_in <= '{data_drive: 1'b1, wdata: 8'h5a, default: '0};
		@(posedge clk_sys_in);
		bus_req_in <= '0;
		shutdown_in <= 1'b1;
		{gpio_pu_dis_in, hi_pu_dis_in} <= '0;
		repeat (2) look();
		chk(low_addr_data_port_oe_out, 8'ha5);
		chk(low_addr_data_port_out & 8'ha5, 8'h00);
		chk(low_addr_data_port_pu_out & 8'h5a, 8'h5a);
		chk({high_addr_port_oe_out, high_addr_port_pu_out}, 16'h00ff);
		chk(general_io_port_out, 8'h0f);
		chk({prog_strobe_n_oe_out, prog_strobe_n_pu_out}, 2'h1);
		@(posedge clk_sys_in);
		quiet_in <= 1'b1;
		look();
		chk(high_addr_port_pu_out, 8'hff);
		@(posedge clk_sys_in);
		{shutdown_in, quiet_in} <= '0;
	endtask : t_quiet

	task automatic t_emul(input logic [2:0] str, input logic [1:0] irq);
		@(posedge clk_sys_in);
		emu_str <= str;
		{emu_int_a_in, emu_int_b_in} <= irq;
		{core_clk_sel_in, core_clk_in} <= {1'b0, irq[1]};
		repeat (2) look();
		chk({low_addr_data_port_oe_out, low_addr_data_port_pu_out}, 16'h0);
		chk({high_addr_port_oe_out, high_addr_port_pu_out}, 16'h0);
		chk({general_io_port_oe_out, general_io_port_pu_out}, 16'h0);
		chk({latch_strobe_oe_out, rd_strobe_n_oe_out, wr_strobe_n_oe_out,
			prog_strobe_n_oe_out, prog_strobe_n_pu_out}, 5'h0);
		chk({select_decode_a_out, select_decode_b_out}, irq);
		chk(select_c_or_core_clock_pin_out, irq[1]);
		chk({emu_latch_out, emu_rd_out, emu_wr_out}, str ^ 3'h3);
	endtask : t_emul

	////////////////////////////////////////////////////////////////////////
	initial begin
		arst_n_in = 1'b0;
		{core_rst_in, shutdown_in, quiet_in, core_clk_sel_in} = '0;
		{decode_a_hit_in, decode_b_hit_in, decode_c_hit_in} = '0;
		{core_clk_in, emu_int_a_in, emu_int_b_in, emu_drv} = '0;
		emu_str = 3'h3;
		mode_strap_in = MBPM_STRAP_HIGH;
		bus_req_in = '0;
		{gpio_pu_dis_in, hi_pu_dis_in, gpio_chg_en_in, ext_en, ext_val} = '0;
		gpio_sfr_in = 8'h0f;
		hi_sfr_in = 8'h3c;
		n_fail = 0;
		n_compared = 0;
		repeat (5) @(posedge clk_sys_in);
		#1;
		chk({low_addr_data_port_pu_out, high_addr_port_pu_out}, 16'hffff);
		chk({select_decode_a_out, select_decode_b_out}, 2'h3);
		@(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		core_reset(MBPM_STRAP_HIGH);
		t_bus();
		t_sel();
		t_ports();
		t_change();
		t_quiet();
		core_reset(MBPM_STRAP_LOW);
		emu_drv <= 1'b1;
		t_emul(3'h5, 2'h2);
		t_emul(3'h2, 2'h1);
		@(posedge clk_sys_in);
		emu_drv <= 1'b0;
		core_reset(MBPM_STRAP_HIGH);
		stop_test();
	end
endmodule : mbpm_pin_ctrl_bench
`default_nettype wire
